/* File: rtl/tal_alert_core.sv */
// Temperature alert, limit and configuration core with link-side register port
`timescale 1ns/1ps
module tal_alert_core import tal_pkg::*; #(
	parameter int CONV_CYC_R0 = TAL_T_CONV_R0_MS * (TAL_CLK_HZ / 1000),
	parameter int CONV_CYC_R1 = TAL_T_CONV_R1_MS * (TAL_CLK_HZ / 1000),
	parameter int CONV_CYC_R2 = TAL_T_CONV_R2_MS * (TAL_CLK_HZ / 1000),
	parameter int CONV_CYC_R3 = TAL_T_CONV_R3_MS * (TAL_CLK_HZ / 1000),
	// Identification values are arbitrary
	parameter logic [15:0] MAKER_ID = 16'h1234,
	parameter logic [15:0] PART_REV = 16'h0A01
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic link_clk,
	input wire logic lk_req,
	input wire tal_req_t lk_cmd,
	input wire logic [12:0] temp_smp,
	output logic lk_busy,
	output logic lk_done,
	output logic [15:0] lk_rdata,
	output logic alert_out,
	output logic alert_oe,
	output logic conv_run
);
	function automatic logic sgt(input logic [12:0] a, input logic [12:0] b);
		return $signed(a) > $signed(b);
	endfunction

	function automatic logic slt(input logic [12:0] a, input logic [12:0] b);
		return $signed(a) < $signed(b);
	endfunction

	function automatic logic [12:0] quant(input logic [12:0] t, input logic [1:0] r);
		case (r)
			2'h0: quant = t & 13'h1FF8;
			2'h1: quant = t & 13'h1FFC;
			2'h2: quant = t & 13'h1FFE;
			default: quant = t;
		endcase
	endfunction

	function automatic logic [21:0] conv_limit(input logic [1:0] r);
		case (r)
			2'h0: conv_limit = 22'(CONV_CYC_R0 - 1);
			2'h1: conv_limit = 22'(CONV_CYC_R1 - 1);
			2'h2: conv_limit = 22'(CONV_CYC_R2 - 1);
			default: conv_limit = 22'(CONV_CYC_R3 - 1);
		endcase
	endfunction

	// Link clock domain
	tal_lk_state_t lk_st_ff, nxt_lk_st;
	tal_req_t lk_hold_ff, nxt_lk_hold;
	logic lk_tgl_ff, nxt_lk_tgl;
	logic lk_ack_seen_ff, nxt_lk_ack_seen;
	logic lk_busy_ff, nxt_lk_busy;
	logic lk_done_ff, nxt_lk_done;
	logic [15:0] lk_rdata_ff, nxt_lk_rdata;
	logic lk_ack_sync;
	logic lk_ce_sync;
	logic ack_tgl_ff;
	logic [15:0] rdata_ff;

	tal_sync #(.W(1)) u_ack_sync (
		.clk(link_clk),
		.rst_b(rst_b),
		.en(1'b1),
		.d(ack_tgl_ff),
		.q(lk_ack_sync)
	);

	tal_sync #(.W(1)) u_ce_sync (
		.clk(link_clk),
		.rst_b(rst_b),
		.en(1'b1),
		.d(ce),
		.q(lk_ce_sync)
	);

	always_comb begin
		nxt_lk_st = lk_st_ff;
		nxt_lk_hold = lk_hold_ff;
		nxt_lk_tgl = lk_tgl_ff;
		nxt_lk_ack_seen = lk_ack_seen_ff;
		nxt_lk_busy = lk_busy_ff;
		nxt_lk_done = lk_done_ff;
		nxt_lk_rdata = lk_rdata_ff;
		if (lk_ce_sync) begin
			nxt_lk_done = 1'b0;
			case (lk_st_ff)
				TAL_LK_IDLE: begin
					if (lk_req) begin
						nxt_lk_hold = lk_cmd;
						nxt_lk_tgl = ~lk_tgl_ff;
						nxt_lk_busy = 1'b1;
						nxt_lk_st = TAL_LK_WAIT;
					end
				end
				TAL_LK_WAIT: begin
					if (lk_ack_sync != lk_ack_seen_ff) begin
						nxt_lk_ack_seen = lk_ack_sync;
						nxt_lk_rdata = rdata_ff;
						nxt_lk_done = 1'b1;
						nxt_lk_busy = 1'b0;
						nxt_lk_st = TAL_LK_IDLE;
					end
				end
				default: nxt_lk_st = TAL_LK_IDLE;
			endcase
		end
	end

	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			lk_st_ff <= TAL_LK_IDLE;
			lk_hold_ff <= '0;
			lk_tgl_ff <= 1'b0;
			lk_ack_seen_ff <= 1'b0;
			lk_busy_ff <= 1'b0;
			lk_done_ff <= 1'b0;
			lk_rdata_ff <= 16'h0000;
		end else begin
			lk_st_ff <= nxt_lk_st;
			lk_hold_ff <= nxt_lk_hold;
			lk_tgl_ff <= nxt_lk_tgl;
			lk_ack_seen_ff <= nxt_lk_ack_seen;
			lk_busy_ff <= nxt_lk_busy;
			lk_done_ff <= nxt_lk_done;
			lk_rdata_ff <= nxt_lk_rdata;
		end
	end

	assign lk_busy = lk_busy_ff;
	assign lk_done = lk_done_ff;
	assign lk_rdata = lk_rdata_ff;

	// Core clock domain
	logic req_sync;
	logic req_seen_ff, nxt_req_seen;
	logic nxt_ack_tgl;
	logic [15:0] nxt_rdata;
	logic [15:0] cfg_ff, nxt_cfg;
	logic [15:0] lim_up_ff, nxt_lim_up;
	logic [15:0] lim_lo_ff, nxt_lim_lo;
	logic [15:0] lim_cr_ff, nxt_lim_cr;
	logic [12:0] amb_ff, nxt_amb;
	logic [1:0] res_ff, nxt_res;
	logic [21:0] conv_cnt_ff, nxt_conv_cnt;
	logic hi_ff, nxt_hi;
	logic lo_ff, nxt_lo;
	logic cr_ff, nxt_cr;
	logic int_ff, nxt_int;
	logic stat_ff, nxt_stat;
	logic alert_out_ff;
	logic alert_oe_ff, nxt_alert_oe;
	logic conv_run_ff, nxt_conv_run;
	logic new_req;
	logic cfg_wr;
	logic icl_wr;
	logic conv_done;
	logic int_mode;
	logic int_event;
	logic locked;
	logic [12:0] hyst;
	logic [12:0] tnew;
	logic raw_alert;

	tal_sync #(.W(1)) u_req_sync (
		.clk(ref_clk),
		.rst_b(rst_b),
		.en(ce),
		.d(lk_tgl_ff),
		.q(req_sync)
	);

	assign new_req = req_sync != req_seen_ff;
	assign cfg_wr = new_req && lk_hold_ff.wr && lk_hold_ff.addr == TAL_ADDR_CFG;
	assign icl_wr = cfg_wr && lk_hold_ff.wdata[TAL_CFG_ICLR];
	assign locked = cfg_ff[TAL_CFG_LKCR] | cfg_ff[TAL_CFG_LKWIN];
	assign int_mode = cfg_ff[TAL_CFG_MODE] & ~cfg_ff[TAL_CFG_CRONLY];
	assign conv_done = ~cfg_ff[TAL_CFG_SHDN] && conv_cnt_ff >= conv_limit(res_ff);
	assign tnew = quant(temp_smp, res_ff);

	always_comb begin
		case (cfg_ff[TAL_CFG_HYST+1:TAL_CFG_HYST])
			2'h0: hyst = TAL_HYST_0;
			2'h1: hyst = TAL_HYST_1;
			2'h2: hyst = TAL_HYST_2;
			default: hyst = TAL_HYST_3;
		endcase
	end

	always_comb begin
		nxt_req_seen = req_seen_ff;
		nxt_ack_tgl = ack_tgl_ff;
		nxt_rdata = rdata_ff;
		nxt_cfg = cfg_ff;
		nxt_lim_up = lim_up_ff;
		nxt_lim_lo = lim_lo_ff;
		nxt_lim_cr = lim_cr_ff;
		nxt_res = res_ff;
		if (new_req) begin
			nxt_req_seen = req_sync;
			nxt_ack_tgl = ~ack_tgl_ff;
			if (lk_hold_ff.wr) begin
				case (lk_hold_ff.addr)
					TAL_ADDR_CFG: begin
						nxt_cfg[3:0] = lk_hold_ff.wdata[3:0];
						nxt_cfg[TAL_CFG_LKCR] = cfg_ff[TAL_CFG_LKCR] | lk_hold_ff.wdata[TAL_CFG_LKCR];
						nxt_cfg[TAL_CFG_LKWIN] = cfg_ff[TAL_CFG_LKWIN] | lk_hold_ff.wdata[TAL_CFG_LKWIN];
						nxt_cfg[TAL_CFG_SHDN] = lk_hold_ff.wdata[TAL_CFG_SHDN] & (~locked | cfg_ff[TAL_CFG_SHDN]);
						if (!locked) begin
							nxt_cfg[TAL_CFG_HYST+1:TAL_CFG_HYST] = lk_hold_ff.wdata[TAL_CFG_HYST+1:TAL_CFG_HYST];
						end
					end
					TAL_ADDR_UPPER: nxt_lim_up = cfg_ff[TAL_CFG_LKWIN] ? lim_up_ff : lk_hold_ff.wdata & TAL_LIM_MASK;
					TAL_ADDR_LOWER: nxt_lim_lo = cfg_ff[TAL_CFG_LKWIN] ? lim_lo_ff : lk_hold_ff.wdata & TAL_LIM_MASK;
					TAL_ADDR_CRIT: nxt_lim_cr = cfg_ff[TAL_CFG_LKCR] ? lim_cr_ff : lk_hold_ff.wdata & TAL_LIM_MASK;
					TAL_ADDR_RES: nxt_res = lk_hold_ff.wdata[1:0];
					default: nxt_res = res_ff;
				endcase
				nxt_rdata = 16'h0000;
			end else begin
				case (lk_hold_ff.addr)
					TAL_ADDR_CFG: nxt_rdata = cfg_ff | {11'h000, stat_ff, 4'h0};
					TAL_ADDR_UPPER: nxt_rdata = lim_up_ff;
					TAL_ADDR_LOWER: nxt_rdata = lim_lo_ff;
					TAL_ADDR_CRIT: nxt_rdata = lim_cr_ff;
					TAL_ADDR_AMB: nxt_rdata = {cr_ff, hi_ff, lo_ff, amb_ff};
					TAL_ADDR_MAKER: nxt_rdata = MAKER_ID;
					TAL_ADDR_PART: nxt_rdata = PART_REV;
					TAL_ADDR_RES: nxt_rdata = {14'h0000, res_ff};
					default: nxt_rdata = 16'h0000;
				endcase
			end
		end
	end

	always_comb begin
		nxt_conv_cnt = conv_cnt_ff;
		nxt_amb = amb_ff;
		nxt_hi = hi_ff;
		nxt_lo = lo_ff;
		nxt_cr = cr_ff;
		int_event = 1'b0;
		if (cfg_ff[TAL_CFG_SHDN]) begin
			nxt_conv_cnt = 22'h000000;
		end else if (conv_done) begin
			nxt_conv_cnt = 22'h000000;
			nxt_amb = tnew;
			if (sgt(tnew, lim_cr_ff[12:0])) begin
				nxt_cr = 1'b1;
			end else if (slt(tnew, lim_cr_ff[12:0] - hyst)) begin
				nxt_cr = 1'b0;
			end
			if (sgt(tnew, lim_up_ff[12:0])) begin
				nxt_hi = 1'b1;
			end else if (slt(tnew, lim_up_ff[12:0] - hyst)) begin
				nxt_hi = 1'b0;
			end
			if (slt(tnew, lim_lo_ff[12:0] - hyst)) begin
				nxt_lo = 1'b1;
			end else if (sgt(tnew, lim_lo_ff[12:0])) begin
				nxt_lo = 1'b0;
			end
			int_event = (nxt_hi & ~hi_ff) | (nxt_lo & ~lo_ff);
		end else begin
			nxt_conv_cnt = conv_cnt_ff + 22'h000001;
		end
	end

	always_comb begin
		nxt_int = int_ff;
		if (!int_mode) begin
			nxt_int = 1'b0;
		end else if (int_event) begin
			nxt_int = 1'b1;
		end else if (icl_wr) begin
			nxt_int = 1'b0;
		end
		if (nxt_cfg[TAL_CFG_CRONLY]) begin
			raw_alert = nxt_cr;
		end else if (nxt_cfg[TAL_CFG_MODE]) begin
			raw_alert = nxt_cr | nxt_int;
		end else begin
			raw_alert = nxt_cr | nxt_hi | nxt_lo;
		end
		nxt_stat = nxt_cfg[TAL_CFG_EN] & raw_alert;
		if (cfg_ff[TAL_CFG_SHDN]) begin
			nxt_stat = nxt_stat & stat_ff;
		end
		nxt_alert_oe = nxt_stat ^ nxt_cfg[TAL_CFG_POL];
		nxt_conv_run = ~nxt_cfg[TAL_CFG_SHDN];
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_seen_ff <= 1'b0;
			ack_tgl_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			cfg_ff <= TAL_CFG_RST;
			lim_up_ff <= TAL_LIM_RST;
			lim_lo_ff <= TAL_LIM_RST;
			lim_cr_ff <= TAL_LIM_RST;
			amb_ff <= TAL_AMB_RST;
			res_ff <= TAL_RES_RST;
			conv_cnt_ff <= 22'h000000;
			hi_ff <= 1'b0;
			lo_ff <= 1'b0;
			cr_ff <= 1'b0;
			int_ff <= 1'b0;
			stat_ff <= 1'b0;
			alert_out_ff <= 1'b0;
			alert_oe_ff <= 1'b0;
			conv_run_ff <= 1'b1;
		end else if (ce) begin
			req_seen_ff <= nxt_req_seen;
			ack_tgl_ff <= nxt_ack_tgl;
			rdata_ff <= nxt_rdata;
			cfg_ff <= nxt_cfg;
			lim_up_ff <= nxt_lim_up;
			lim_lo_ff <= nxt_lim_lo;
			lim_cr_ff <= nxt_lim_cr;
			amb_ff <= nxt_amb;
			res_ff <= nxt_res;
			conv_cnt_ff <= nxt_conv_cnt;
			hi_ff <= nxt_hi;
			lo_ff <= nxt_lo;
			cr_ff <= nxt_cr;
			int_ff <= nxt_int;
			stat_ff <= nxt_stat;
			alert_out_ff <= 1'b0;
			alert_oe_ff <= nxt_alert_oe;
			conv_run_ff <= nxt_conv_run;
		end
	end

	assign alert_out = alert_out_ff;
	assign alert_oe = alert_oe_ff;
	assign conv_run = conv_run_ff;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	AST_STATUS_READ: assert property (ce && new_req && !lk_hold_ff.wr && lk_hold_ff.addr == TAL_ADDR_CFG
		|=> rdata_ff[TAL_CFG_STAT] == $past(stat_ff))
		else $error("status bit read back wrong");
	AST_NO_SET_SHDN: assert property (ce && cfg_ff[TAL_CFG_SHDN] && !stat_ff |=> !stat_ff)
		else $error("alert status rose in shutdown");
	AST_LOCK_LIMITS: assert property (ce && cfg_ff[TAL_CFG_LKCR] && cfg_ff[TAL_CFG_LKWIN]
		|=> $stable(lim_cr_ff) && $stable(lim_up_ff) && $stable(lim_lo_ff))
		else $error("locked limit changed");
	AST_LOCKED_WRITE_ACK: assert property (ce && new_req && lk_hold_ff.wr && cfg_ff[TAL_CFG_LKCR]
		|=> ack_tgl_ff != $past(ack_tgl_ff) && $stable(lim_cr_ff))
		else $error("locked write not acknowledged or not ignored");
	AST_CRIT_ONLY: assert property ($past(ce) && !$past(cfg_ff[TAL_CFG_SHDN]) && cfg_ff[TAL_CFG_CRONLY]
		|-> stat_ff == (cfg_ff[TAL_CFG_EN] & cr_ff))
		else $error("critical-only output does not follow critical zone");
	AST_PIN_POL: assert property (alert_oe == (stat_ff ^ cfg_ff[TAL_CFG_POL]))
		else $error("pin drive does not match status and polarity");
	AST_SHDN_HOLD: assert property (ce && cfg_ff[TAL_CFG_SHDN] && stat_ff && !cfg_wr |=> stat_ff)
		else $error("alert dropped during shutdown");
	AST_DEASSERT_CONV: assert property ($fell(stat_ff) && !$past(cfg_wr) |-> $past(conv_done))
		else $error("alert deasserted without a conversion");
	AST_INT_SET: assert property (ce && conv_done && int_mode && int_event && !cfg_wr
		|=> int_ff ##0 (stat_ff == cfg_ff[TAL_CFG_EN]))
		else $error("interrupt not raised on window exit");
	AST_INT_CLEAR: assert property (ce && icl_wr && !int_event |=> !int_ff)
		else $error("interrupt clear ignored");
	AST_INT_HOLD_SHDN: assert property (ce && int_ff && int_mode && !cfg_wr |=> int_ff)
		else $error("latched interrupt lost");

	COV_CRIT: cover property (ce && !cr_ff ##1 cr_ff);
	COV_INT_CYCLE: cover property (ce && int_event && int_mode ##[1:50] icl_wr);
	COV_SHDN_ASSERTED: cover property (stat_ff && cfg_ff[TAL_CFG_SHDN]);
endmodule

/* File: rtl/tal_pkg.sv */
// Constants and types shared by the temperature alert block
package tal_pkg;
	localparam logic [7:0] TAL_ADDR_CFG = 8'h01;
	localparam logic [7:0] TAL_ADDR_UPPER = 8'h02;
	localparam logic [7:0] TAL_ADDR_LOWER = 8'h03;
	localparam logic [7:0] TAL_ADDR_CRIT = 8'h04;
	localparam logic [7:0] TAL_ADDR_AMB = 8'h05;
	localparam logic [7:0] TAL_ADDR_MAKER = 8'h06;
	localparam logic [7:0] TAL_ADDR_PART = 8'h07;
	localparam logic [7:0] TAL_ADDR_RES = 8'h08;
	localparam logic [15:0] TAL_CFG_RST = 16'h0000;
	localparam logic [15:0] TAL_LIM_RST = 16'h0000;
	localparam logic [12:0] TAL_AMB_RST = 13'h0000;
	localparam logic [1:0] TAL_RES_RST = 2'h3;
	localparam int TAL_CFG_MODE = 0;
	localparam int TAL_CFG_POL = 1;
	localparam int TAL_CFG_CRONLY = 2;
	localparam int TAL_CFG_EN = 3;
	localparam int TAL_CFG_STAT = 4;
	localparam int TAL_CFG_ICLR = 5;
	localparam int TAL_CFG_LKCR = 6;
	localparam int TAL_CFG_LKWIN = 7;
	localparam int TAL_CFG_SHDN = 8;
	localparam int TAL_CFG_HYST = 9;
	localparam logic [15:0] TAL_LIM_MASK = 16'h1FFC;
	localparam logic [12:0] TAL_HYST_0 = 13'h0000;
	localparam logic [12:0] TAL_HYST_1 = 13'h0018;
	localparam logic [12:0] TAL_HYST_2 = 13'h0030;
	localparam logic [12:0] TAL_HYST_3 = 13'h0060;
	localparam int TAL_CLK_HZ = 10000000;
	localparam int TAL_T_CONV_R0_MS = 30;
	localparam int TAL_T_CONV_R1_MS = 65;
	localparam int TAL_T_CONV_R2_MS = 130;
	localparam int TAL_T_CONV_R3_MS = 250;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
	} tal_req_t;
	typedef enum {TAL_LK_IDLE, TAL_LK_WAIT} tal_lk_state_t;
endpackage

/* File: rtl/tal_sync.sv */
// Two-stage synchroniser for levels and toggles
`timescale 1ns/1ps
module tal_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_q;

	always_comb begin
		nxt_meta = en ? d : meta_ff;
		nxt_q = en ? meta_ff : q_ff;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			q_ff <= nxt_q;
		end
	end

	assign q = q_ff;
endmodule

/* File: verif/tal_host_model.sv */
// Host controller model issuing register transfers on the link port
`timescale 1ns/1ps
module tal_host_model import tal_pkg::*; (
	input wire logic link_clk,
	input wire logic lk_busy,
	input wire logic lk_done,
	input wire logic [15:0] lk_rdata,
	output logic lk_req,
	output tal_req_t lk_cmd
);
	initial begin
		lk_req = 1'b0;
		lk_cmd = '1;
	end
	// One transfer after gap idle cycles; ok is low if no answer came
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] wdata, input int gap,
		output logic [15:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		rd = 16'hFFFF;
		repeat (gap + 1) @(posedge link_clk);
		#2;
		lk_req = 1'b1;
		lk_cmd = '{wr: wr, addr: addr, wdata: wdata};
		@(posedge link_clk);
		#2;
		lk_req = 1'b0;
		lk_cmd = ~lk_cmd;
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge link_clk);
			#1;
			if (lk_done === 1'b1 && lk_busy === 1'b0) begin
				ok = 1'b1;
				rd = lk_rdata;
			end
		end
	endtask
	// Acknowledge a latched interrupt
	task automatic ack_irq(input logic [15:0] cfg, output logic ok);
		logic [15:0] r;
		xfer(1'b1, TAL_ADDR_CFG, cfg | 16'h0020, 0, r, ok);
	endtask
endmodule

/* File: verif/tb.sv */
// Self-checking testbench of the temperature alert core
`timescale 1ns/1ps
module tb import tal_pkg::*; ;
	localparam int CR = 40;
	// Identification values are arbitrary
	localparam logic [15:0] MAKER = 16'h5A3C;
	localparam logic [15:0] PART = 16'h0C07;
	localparam logic [12:0] T20 = 13'h0140;
	localparam logic [12:0] T30 = 13'h01E0;
	logic ref_clk, link_clk, rst_b, ce, lk_req, lk_busy, lk_done, alert_out, alert_oe, conv_run;
	logic [12:0] temp_smp;
	logic [15:0] lk_rdata;
	tal_req_t lk_cmd;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	tal_alert_core #(.CONV_CYC_R0(20), .CONV_CYC_R1(25), .CONV_CYC_R2(30), .CONV_CYC_R3(CR),
		.MAKER_ID(MAKER), .PART_REV(PART)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
		.link_clk(link_clk), .lk_req(lk_req), .lk_cmd(lk_cmd), .temp_smp(temp_smp), .lk_busy(lk_busy),
		.lk_done(lk_done), .lk_rdata(lk_rdata), .alert_out(alert_out), .alert_oe(alert_oe), .conv_run(conv_run));
	tal_host_model i_host (.link_clk(link_clk), .lk_busy(lk_busy), .lk_done(lk_done), .lk_rdata(lk_rdata),
		.lk_req(lk_req), .lk_cmd(lk_cmd));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		#37;
		forever #62.5 link_clk = ~link_clk;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] r;
		logic ok;
		i_host.xfer(1'b1, a, d, 0, r, ok);
		chk("write answer", 16'h0000, ok ? r : 16'hFFFF);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input int gap);
		logic [15:0] r;
		logic ok;
		i_host.xfer(1'b0, a, e, gap, r, ok);
		chk($sformatf("register %h", a), e, ok ? r : ~e);
	endtask
	task automatic pin(input string nm, input logic e, input logic g);
		chk(nm, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic conv_wait;
		repeat (2 * CR + 10) @(posedge ref_clk);
	endtask
	task automatic set_temp(input logic [12:0] t);
		@(posedge ref_clk);
		#2;
		temp_smp = t;
	endtask
	task automatic do_reset;
		rst_b = 1'b0;
		repeat (2) @(posedge ref_clk);
		#2;
		rst_b = 1'b1;
		repeat (4) @(posedge link_clk);
	endtask
	task automatic t_reset;
		logic [15:0] exp_tab [9];
		exp_tab = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, MAKER, PART, 16'h0003, 16'h0000};
		pin("conv_run", 1'b1, conv_run);
		pin("alert_oe", 1'b0, alert_oe);
		pin("alert_out", 1'b0, alert_out);
		for (int i = 0; i < 9; i++) begin
			rd(8'(i + 1), exp_tab[i], i % 3);
		end
		$display("test reset done");
	endtask
	task automatic t_comp;
		wr(TAL_ADDR_CRIT, 16'h0280);
		wr(TAL_ADDR_UPPER, 16'h0190);
		set_temp(T30);
		wr(TAL_ADDR_CFG, 16'h0008);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h0018, 0);
		pin("alert_oe", 1'b1, alert_oe);
		wr(TAL_ADDR_CFG, 16'h000A);
		pin("alert_oe", 1'b0, alert_oe);
		wr(TAL_ADDR_CFG, 16'h0002);
		rd(TAL_ADDR_CFG, 16'h0002, 1);
		pin("alert_oe", 1'b1, alert_oe);
		$display("test comparator done");
	endtask
	task automatic t_shdn;
		wr(TAL_ADDR_CFG, 16'h0008);
		conv_wait();
		wr(TAL_ADDR_CFG, 16'h0108);
		pin("conv_run", 1'b0, conv_run);
		set_temp(T20);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h0118, 0);
		wr(TAL_ADDR_CFG, 16'h0008);
		pin("alert_oe", 1'b1, alert_oe);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h0008, 0);
		pin("conv_run", 1'b1, conv_run);
		set_temp(T30);
		wr(TAL_ADDR_CFG, 16'h0000);
		conv_wait();
		wr(TAL_ADDR_CFG, 16'h0100);
		wr(TAL_ADDR_CFG, 16'h0108);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h0108, 0);
		pin("alert_oe", 1'b0, alert_oe);
		wr(TAL_ADDR_CFG, 16'h0000);
		$display("test shutdown done");
	endtask
	task automatic t_irq;
		logic ok;
		set_temp(T20);
		wr(TAL_ADDR_CFG, 16'h0009);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h0009, 0);
		set_temp(T30);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h0019, 0);
		set_temp(T20);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h0019, 0);
		wr(TAL_ADDR_CFG, 16'h0109);
		rd(TAL_ADDR_CFG, 16'h0119, 2);
		wr(TAL_ADDR_CFG, 16'h0009);
		i_host.ack_irq(16'h0009, ok);
		pin("clear answer", 1'b1, ok);
		rd(TAL_ADDR_CFG, 16'h0009, 0);
		set_temp(13'h1FF0);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h0019, 0);
		i_host.ack_irq(16'h0009, ok);
		pin("clear answer", 1'b1, ok);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h0009, 0);
		wr(TAL_ADDR_CFG, 16'h0000);
		$display("test interrupt done");
	endtask
	task automatic t_crit;
		wr(TAL_ADDR_CRIT, 16'h0280);
		set_temp(T30);
		wr(TAL_ADDR_CFG, 16'h000D);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h000D, 0);
		set_temp(13'h02D0);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h001D, 0);
		set_temp(13'h0230);
		conv_wait();
		rd(TAL_ADDR_CFG, 16'h000D, 0);
		wr(TAL_ADDR_CFG, 16'h0000);
		$display("test critical done");
	endtask
	task automatic t_res;
		logic [12:0] q;
		set_temp(13'h01E7);
		for (int i = 0; i < 4; i++) begin
			wr(TAL_ADDR_RES, 16'(i));
			rd(TAL_ADDR_RES, 16'(i), 0);
			conv_wait();
			q = 13'h01E7 & (13'h1FFF << (3 - i));
			rd(TAL_ADDR_AMB, {3'b010, q}, 0);
		end
		$display("test resolution done");
	endtask
	task automatic t_lock;
		wr(TAL_ADDR_CFG, 16'h00C0);
		wr(TAL_ADDR_UPPER, 16'h0320);
		rd(TAL_ADDR_UPPER, 16'h0190, 0);
		wr(TAL_ADDR_CRIT, 16'h0320);
		rd(TAL_ADDR_CRIT, 16'h0280, 0);
		do_reset();
		rd(TAL_ADDR_CFG, 16'h0000, 0);
		rd(TAL_ADDR_UPPER, 16'h0000, 0);
		$display("test lock done");
	endtask
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		temp_smp = 13'h0000;
		do_reset();
		t_reset();
		t_comp();
		t_shdn();
		t_irq();
		t_crit();
		t_res();
		t_lock();
		summarize();
	end
endmodule
